// ### common/ttx_map.svh
// Notes on behaviour
// - In 525-line format a packet holds 32 data bytes; display rows stay 40 wide.
// - Tabulated ordinary packet fills columns 32-39 of four rows from packet number with LSBs cleared.
// - Tabulated data gets the same error check as 625-line data at that location.
// - Rolling time comes from tabulated packets 1-3; parallel mode needs matching magazine.
// - Tabulated packet number zero is ignored.
// - Tabulated packet 24 first 8 bytes extend prompt row wherever packet 24 goes.
// - Link packet 27/0 untabulated is Hamming checked and stored; tabulated one is dropped.
// - Magazine bits all zero mean magazine 4; service packet is 4/30.
// - First 20 service bytes decoded as 625-line, stored from either tabulated version.
// - Last 12 service bytes hold half the status message; final 4 of a tabulated one are never written.
// - Packet 26 gives ten triplets; tabulation is designation MSB; last byte ignored.
// - Standard chosen automatically; no recognised packets means switch system.
// - 625 or 525 detected flag follows decision; both clear while undecided.
// - Override bits pick auto, force 525, force 625, or 625 timing with 525 standard.
// - Untabulated ordinary packet goes to row of its number; control data to row 25.
// - Packet 24 goes to basic row 24 when row select set, else extension row 0.
// - Magazine-4 packet 30 sets service flag in 525 mode; write zero clears it.
// - In 525 mode only untabulated link packet 27/0 sets link flag.
`ifndef TTX_MAP_SVH
`define TTX_MAP_SVH

`define TTX_REG_CTRL      4'h0
`define TTX_REG_OVERRIDE  4'h4
`define TTX_REG_STATUS    4'h8

`define TTX_CTRL_EIGHT_BIT   0
`define TTX_CTRL_EXT24_SEL   1
`define TTX_CTRL_PAR_MAG     2
`define TTX_ST_LONG          0
`define TTX_ST_SHORT         1
`define TTX_ST_SERVICE       2
`define TTX_ST_LINK          3
`define TTX_ST_TIMING525     4

`define TTX_CTRL_RESET       3'h0
`define TTX_OVERRIDE_RESET   2'h0

`define TTX_BYTES_525        6'h20
`define TTX_BYTES_625        6'h28
`define TTX_TAB_COL          6'h20
`define TTX_SVC_CODED        6'h14
`define TTX_SVC_HALF_END     6'h1C
`define TTX_SVC_SHIFT        6'h0C
`define TTX_P26_LAST_525     6'h1E
`define TTX_P26_LAST_625     6'h27
`define TTX_ROW_CTRL         5'h19
`define TTX_ROW_P24          5'h18
`define TTX_ROW_EXT_P24      5'h00
`define TTX_ROW_EXT_LINK     5'h01
`define TTX_ROW_EXT_SVC      5'h02

`define TTX_LOCK_PKTS        4
`define TTX_MISS_LINES       200

`endif

// ### common/ttx_pkg.sv
package ttx_pkg;
    typedef enum logic [1:0] {
        DET_SEEK_625 = 2'b00,
        DET_SEEK_525 = 2'b01,
        DET_LOCK_625 = 2'b10,
        DET_LOCK_525 = 2'b11
    } ttx_det_e;
    typedef enum logic [1:0] {
        CHK_NONE    = 2'b00,
        CHK_PARITY  = 2'b01,
        CHK_HAMMING = 2'b10
    } ttx_chk_e;
    typedef logic [1:0] ttx_ovr_t;
endpackage

// ### core/ttx_acq.sv
`timescale 1ns/10ps
`include "ttx_map.svh"
module ttx_acq #(
    parameter int LOCK_PKTS  = `TTX_LOCK_PKTS,
    parameter int MISS_LINES = `TTX_MISS_LINES
) (
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic              ce,
    input  wire logic [3:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    input  wire logic              line_pulse,
    input  wire logic              pkt_start,
    input  wire logic [2:0]        pkt_mag,
    input  wire logic [4:0]        pkt_num,
    input  wire logic [3:0]        pkt_desig,
    input  wire logic              pkt_acquire,
    input  wire logic              pkt_mag_match,
    input  wire logic              pr_no_check,
    input  wire logic              byte_valid,
    input  wire logic [7:0]        byte_data,
    output logic                   timing_525,
    output logic                   mem_we,
    output logic                   mem_ext,
    output logic      [4:0]        mem_row,
    output logic      [5:0]        mem_col,
    output logic      [7:0]        mem_data,
    output ttx_pkg::ttx_chk_e      mem_check,
    output logic                   trip_valid,
    output logic      [23:0]       trip_data,
    output logic      [4:0]        trip_desig,
    output logic      [3:0]        trip_num
);
    import ttx_pkg::*;

    if (LOCK_PKTS < 1 || LOCK_PKTS > 15 || MISS_LINES < 2 || MISS_LINES > 4095) begin : g_chk
        $error("ttx_acq: LOCK_PKTS or MISS_LINES out of range");
    end

    localparam logic [3:0]  LOCK_LAST = 4'(LOCK_PKTS - 1);
    localparam logic [11:0] MISS_LAST = 12'(MISS_LINES - 1);

    // Register file
    logic [2:0]  ctrl_r;
    ttx_ovr_t    ovr_r;
    logic        svc_flag_r;
    logic        link_flag_r;
    logic        ack_r;
    logic [31:0] rdata_r;
    // Packet state
    logic [4:0]  num_r;
    logic [2:0]  mag_r;
    logic [3:0]  desig_r;
    logic        acq_r;
    logic        magok_r;
    logic [5:0]  idx_r;
    logic        hdr_pend_r;
    // Detection
    ttx_det_e    det_r;
    ttx_det_e    det_nxt;
    logic [3:0]  hit_cnt_r;
    logic [11:0] miss_cnt_r;
    // Outputs
    logic        mem_we_r;
    logic        mem_ext_r;
    logic [4:0]  mem_row_r;
    logic [5:0]  mem_col_r;
    logic [7:0]  mem_data_r;
    ttx_chk_e    mem_chk_r;
    logic [15:0] trip_acc_r;
    logic [1:0]  trip_ph_r;
    logic        trip_valid_r;
    logic [23:0] trip_data_r;
    logic [4:0]  trip_desig_r;
    logic [3:0]  trip_num_r;

    function automatic logic [4:0] p24_row(input logic sel);
        return sel ? `TTX_ROW_P24 : `TTX_ROW_EXT_P24;
    endfunction

    // Bus decode
    wire req      = avs_read | avs_write;
    wire sel_ctrl = avs_address == `TTX_REG_CTRL;
    wire sel_ovr  = avs_address == `TTX_REG_OVERRIDE;
    wire sel_st   = avs_address == `TTX_REG_STATUS;
    wire wr_go    = ce & avs_write & ack_r & avs_byteenable[0];

    // Standard selection
    wire auto_mode = ovr_r == 2'b00;
    wire std525    = auto_mode ? det_r[0] : ovr_r[0];
    wire tim525    = auto_mode ? det_r[0] : (ovr_r == 2'b01);
    wire flag_long  = auto_mode ? (det_r == DET_LOCK_625) : !std525;
    wire flag_short = auto_mode ? (det_r == DET_LOCK_525) : std525;
    wire [4:0] st_word = {tim525, link_flag_r, svc_flag_r, flag_short, flag_long};

    // Packet classification
    wire tab      = std525 & mag_r[2];
    wire mag_zero = std525 ? (mag_r[1:0] == 2'b00) : (mag_r == 3'h0);
    wire [5:0] nbytes = std525 ? `TTX_BYTES_525 : `TTX_BYTES_625;
    wire in_pkt   = idx_r < nbytes;
    wire acc      = ce & byte_valid & in_pkt;
    wire is_hdr   = num_r == 5'h00 && !tab;
    wire is_ord   = num_r != 5'h00 && num_r < 5'h18 && !tab;
    wire is_tab   = tab && num_r != 5'h00 && num_r <= 5'h18;
    wire is_p24   = num_r == 5'h18 && !tab;
    wire is_p26   = num_r == 5'h1A;
    wire is_link  = num_r == 5'h1B && desig_r == 4'h0 && !tab;
    wire is_svc   = num_r == 5'h1E && mag_zero;

    // Tabulated placement
    wire [4:0] tab_row  = {num_r[4:2], 2'b00} + {3'h0, idx_r[4:3]};
    wire [5:0] tab_col  = `TTX_TAB_COL + {3'h0, idx_r[2:0]};
    wire tab_p24        = num_r == 5'h18;
    wire tab_roll       = tab_row == 5'h00;
    wire roll_ok        = !ctrl_r[`TTX_CTRL_PAR_MAG] | magok_r;
    wire tab_we = is_tab & (tab_p24 ? (acq_r & idx_r < 6'h08)
                                    : (tab_roll ? roll_ok : acq_r));
    wire [4:0] tab_row_f = tab_p24 ? p24_row(ctrl_r[`TTX_CTRL_EXT24_SEL]) : tab_row;
    wire tab_ext = tab_p24 & !ctrl_r[`TTX_CTRL_EXT24_SEL];

    // Service packet placement
    wire svc_coded = idx_r < `TTX_SVC_CODED;
    wire svc_we    = is_svc & (!tab | idx_r < `TTX_SVC_HALF_END);
    wire [5:0] svc_col = (tab && !svc_coded) ? idx_r + `TTX_SVC_SHIFT : idx_r;

    // Error check per location: same rule whatever format filled it
    wire ttx_chk_e data_chk = (ctrl_r[`TTX_CTRL_EIGHT_BIT] | pr_no_check) ? CHK_NONE
                                                                           : CHK_PARITY;
    wire hdr_ctrl = is_hdr && idx_r < 6'h08;

    wire      wr_en = acc & ((acq_r & (is_hdr | is_ord | is_p24 | is_link)) | tab_we | svc_we);
    wire      wr_ext = is_link | is_svc | tab_ext | (is_p24 & !ctrl_r[`TTX_CTRL_EXT24_SEL]);
    wire [4:0] wr_row = is_tab  ? tab_row_f :
                        hdr_ctrl ? `TTX_ROW_CTRL :
                        is_hdr  ? 5'h00 :
                        is_p24  ? p24_row(ctrl_r[`TTX_CTRL_EXT24_SEL]) :
                        is_link ? `TTX_ROW_EXT_LINK :
                        is_svc  ? `TTX_ROW_EXT_SVC : num_r;
    wire [5:0] wr_col = is_tab ? tab_col : (is_svc ? svc_col : idx_r);
    wire ttx_chk_e wr_chk = (hdr_ctrl | is_link | (is_svc & svc_coded)) ? CHK_HAMMING :
                            data_chk;

    // Packet 26 triplets
    wire [5:0] p26_last = std525 ? `TTX_P26_LAST_525 : `TTX_P26_LAST_625;
    wire p26_take = acc & is_p26 & acq_r & idx_r != 6'h00 & idx_r <= p26_last;

    // Detection events
    wire link_seen = hdr_pend_r & is_link;
    wire svc_seen  = hdr_pend_r & is_svc;
    wire det_miss  = line_pulse & !pkt_start & miss_cnt_r == MISS_LAST;
    wire det_hit   = pkt_start & hit_cnt_r == LOCK_LAST;

    always_comb begin
        det_nxt = det_r;
        if (!auto_mode) begin
            det_nxt = DET_SEEK_625;
        end else if (det_miss) begin
            det_nxt = det_r[0] ? DET_SEEK_625 : DET_SEEK_525;
        end else if (det_hit) begin
            case (det_r)
                DET_SEEK_625: det_nxt = DET_LOCK_625;
                DET_SEEK_525: det_nxt = DET_LOCK_525;
                default:      det_nxt = det_r;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            det_r      <= DET_SEEK_625;
            hit_cnt_r  <= 4'h0;
            miss_cnt_r <= 12'h000;
        end else if (ce) begin
            det_r <= det_nxt;
            if (det_nxt != det_r || !auto_mode) begin
                hit_cnt_r  <= 4'h0;
                miss_cnt_r <= 12'h000;
            end else if (pkt_start) begin
                miss_cnt_r <= 12'h000;
                if (hit_cnt_r != 4'hF)
                    hit_cnt_r <= hit_cnt_r + 4'h1;
            end else if (line_pulse) begin
                miss_cnt_r <= miss_cnt_r + 12'h001;
            end
        end
    end

    // Registers; a hardware set wins over a software clear
    always_ff @(posedge clock) begin
        if (rst) begin
            ctrl_r      <= `TTX_CTRL_RESET;
            ovr_r       <= `TTX_OVERRIDE_RESET;
            svc_flag_r  <= 1'b0;
            link_flag_r <= 1'b0;
        end else if (ce) begin
            if (wr_go && sel_ctrl)
                ctrl_r <= avs_writedata[2:0];
            if (wr_go && sel_ovr)
                ovr_r <= avs_writedata[1:0];
            if (svc_seen)
                svc_flag_r <= 1'b1;
            else if (wr_go && sel_st && !avs_writedata[`TTX_ST_SERVICE])
                svc_flag_r <= 1'b0;
            if (link_seen)
                link_flag_r <= 1'b1;
            else if (wr_go && sel_st && !avs_writedata[`TTX_ST_LINK])
                link_flag_r <= 1'b0;
        end
    end

    // One wait state on every access; read data settle in the wait cycle
    always_ff @(posedge clock) begin
        if (rst) begin
            ack_r   <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else if (ce) begin
            ack_r   <= req & !ack_r;
            rdata_r <= sel_ctrl ? {29'h0, ctrl_r} :
                       sel_ovr  ? {30'h0, ovr_r}  :
                       sel_st   ? {27'h0, st_word} : 32'h0000_0000;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            num_r      <= 5'h00;
            mag_r      <= 3'h0;
            desig_r    <= 4'h0;
            acq_r      <= 1'b0;
            magok_r    <= 1'b0;
            idx_r      <= `TTX_BYTES_625;
            hdr_pend_r <= 1'b0;
        end else if (ce) begin
            hdr_pend_r <= pkt_start;
            if (pkt_start) begin
                num_r   <= pkt_num;
                mag_r   <= pkt_mag;
                desig_r <= pkt_desig;
                acq_r   <= pkt_acquire;
                magok_r <= pkt_mag_match;
                idx_r   <= 6'h00;
            end else if (acc) begin
                idx_r <= idx_r + 6'h01;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            mem_we_r   <= 1'b0;
            mem_ext_r  <= 1'b0;
            mem_row_r  <= 5'h00;
            mem_col_r  <= 6'h00;
            mem_data_r <= 8'h00;
            mem_chk_r  <= CHK_NONE;
        end else if (ce) begin
            mem_we_r <= wr_en;
            if (wr_en) begin
                mem_ext_r  <= wr_ext;
                mem_row_r  <= wr_row;
                mem_col_r  <= wr_col;
                mem_data_r <= byte_data;
                mem_chk_r  <= wr_chk;
            end
        end
    end

    // Triplets go out whole; a trailing partial triplet is dropped
    always_ff @(posedge clock) begin
        if (rst) begin
            trip_acc_r   <= 16'h0000;
            trip_ph_r    <= 2'h0;
            trip_valid_r <= 1'b0;
            trip_data_r  <= 24'h00_0000;
            trip_desig_r <= 5'h00;
            trip_num_r   <= 4'h0;
        end else if (ce) begin
            trip_valid_r <= 1'b0;
            if (pkt_start) begin
                trip_ph_r  <= 2'h0;
                trip_num_r <= 4'h0;
            end else if (p26_take) begin
                if (trip_ph_r == 2'h2) begin
                    trip_ph_r    <= 2'h0;
                    trip_valid_r <= 1'b1;
                    trip_data_r  <= {byte_data, trip_acc_r};
                    trip_desig_r <= {tab, desig_r};
                    trip_num_r   <= trip_num_r + 4'h1;
                end else begin
                    trip_ph_r  <= trip_ph_r + 2'h1;
                    trip_acc_r <= {byte_data, trip_acc_r[15:8]};
                end
            end
        end
    end

    assign avs_waitrequest = req & !ack_r;
    assign avs_readdata    = rdata_r;
    assign timing_525      = tim525;
    assign mem_we          = mem_we_r & ce;
    assign mem_ext         = mem_ext_r;
    assign mem_row         = mem_row_r;
    assign mem_col         = mem_col_r;
    assign mem_data        = mem_data_r;
    assign mem_check       = mem_chk_r;
    assign trip_valid      = trip_valid_r & ce;
    assign trip_data       = trip_data_r;
    assign trip_desig      = trip_desig_r;
    assign trip_num        = trip_num_r - 4'h1;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst || !ce);

    property p_short_len;
        std525 && byte_valid && idx_r >= `TTX_BYTES_525 && !pkt_start |=> !mem_we_r;
    endproperty
    a_short_len: assert property (p_short_len) else $error("write past byte 32");
    property p_tab_place;
        acc && is_tab && acq_r && num_r >= 5'h04 && num_r < 5'h18 |=>
            mem_we_r && mem_col_r[5:3] == 3'h4 && mem_row_r[1:0] == $past(idx_r[4:3]);
    endproperty
    a_tab_place: assert property (p_tab_place) else $error("tab data misplaced");
    property p_tab_zero;
        acc && tab && num_r == 5'h00 |=> !mem_we_r;
    endproperty
    a_tab_zero: assert property (p_tab_zero) else $error("tab packet 0 stored");
    property p_tab24;
        acc && is_tab && tab_p24 && acq_r && idx_r < 6'h08 |=>
            mem_we_r && mem_row_r == $past(p24_row(ctrl_r[`TTX_CTRL_EXT24_SEL]))
            && mem_ext_r == !$past(ctrl_r[`TTX_CTRL_EXT24_SEL]);
    endproperty
    a_tab24: assert property (p_tab24) else $error("prompt row extension misplaced");
    property p_tab_link;
        acc && tab && num_r == 5'h1B |=> !mem_we_r;
    endproperty
    a_tab_link: assert property (p_tab_link) else $error("tab link stored");
    property p_svc_tail;
        acc && is_svc && tab && idx_r >= `TTX_SVC_HALF_END |=> !mem_we_r;
    endproperty
    a_svc_tail: assert property (p_svc_tail) else $error("message tail stored");
    property p_p26_count;
        trip_valid_r && std525 |-> trip_num_r <= 4'hA;
    endproperty
    a_p26_count: assert property (p_p26_count) else $error("too many triplets");
    property p_switch;
        auto_mode && det_miss && !det_hit |=> det_r[0] != $past(det_r[0]) && hit_cnt_r == 4'h0;
    endproperty
    a_switch: assert property (p_switch) else $error("no system switch");
    property p_undecided;
        auto_mode && !det_r[1] |-> !flag_long && !flag_short;
    endproperty
    a_undecided: assert property (p_undecided) else $error("flag set undecided");
    property p_ovr11;
        ovr_r == 2'b11 |-> !timing_525 && std525 && flag_short && !flag_long;
    endproperty
    a_ovr11: assert property (p_ovr11) else $error("override 11 wrong");
    property p_svc_flag;
        svc_seen |=> svc_flag_r ##1 1'b1;
    endproperty
    a_svc_flag: assert property (p_svc_flag) else $error("service flag missed");
endmodule

// ### tb/ttx_slicer_model.sv
`timescale 1ns/10ps
module ttx_slicer_model (
    input  wire logic       clock,
    output logic            line_pulse,
    output logic            pkt_start,
    output logic [2:0]      pkt_mag,
    output logic [4:0]      pkt_num,
    output logic [3:0]      pkt_desig,
    output logic            pkt_acquire,
    output logic            pkt_mag_match,
    output logic            byte_valid,
    output logic [7:0]      byte_data
);
    initial begin
        line_pulse = 1'b0;
        pkt_start = 1'b0;
        pkt_mag = 3'h0;
        pkt_num = 5'h00;
        pkt_desig = 4'h0;
        pkt_acquire = 1'b0;
        pkt_mag_match = 1'b0;
        byte_valid = 1'b0;
        byte_data = 8'h00;
    end

    // One packet: header strobe, then cnt bytes; gap idle cycles model a slow slicer
    task automatic send(input logic [2:0] m, input logic [4:0] n, input logic [3:0] d,
                        input logic a, input logic mm, input int cnt, input int gap);
        @(posedge clock);
        pkt_start <= 1'b1;
        pkt_mag <= m;
        pkt_num <= n;
        pkt_desig <= d;
        pkt_acquire <= a;
        pkt_mag_match <= mm;
        for (int i = 0; i < cnt; i++) begin
            repeat (gap) begin
                @(posedge clock);
                pkt_start <= 1'b0;
                byte_valid <= 1'b0;
                byte_data <= ~byte_data;
            end
            @(posedge clock);
            pkt_start <= 1'b0;
            byte_valid <= 1'b1;
            byte_data <= 8'(i) ^ 8'h5A;
        end
        @(posedge clock);
        pkt_start <= 1'b0;
        byte_valid <= 1'b0;
        // Released line must not look like a repeat of the last byte
        byte_data <= ~byte_data;
        pkt_mag <= ~pkt_mag;
        pkt_num <= ~pkt_num;
    endtask

    task automatic lines(input int n);
        repeat (n) begin
            @(posedge clock);
            line_pulse <= 1'b1;
            @(posedge clock);
            line_pulse <= 1'b0;
        end
    endtask
endmodule

// ### tb/testbench.sv
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin err_total++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
module testbench;
    import ttx_pkg::*;
    typedef struct {logic [2:0] m; logic [4:0] n; logic [3:0] d; logic a; int cnt; int wr;
                    logic ext; logic [4:0] row; logic [5:0] col; int trips;} ttx_row_s;
    logic        clock, rst, ce, avs_read, avs_write, avs_waitrequest, timing_525;
    logic [3:0]  avs_address, avs_byteenable, pkt_desig, trip_num, t_num;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic        line_pulse, pkt_start, pkt_acquire, pkt_mag_match, byte_valid;
    logic [2:0]  pkt_mag;
    logic [4:0]  pkt_num, mem_row, trip_desig, f_row, t_desig;
    logic [7:0]  byte_data, mem_data, f_data;
    logic        mem_we, mem_ext, trip_valid, f_ext, pr_no_check;
    logic [5:0]  mem_col, f_col;
    logic [23:0] trip_data, t_data;
    ttx_chk_e    mem_check, f_chk;
    int          err_total, compares, cyc, wcnt, tcnt;
    // wr: expected writes, -1 count not checked, -2 only the triplet count checked
    ttx_row_s rows [11] = '{
        '{3'b101, 5'd9,  4'h0, 1'b1, 32, 32, 1'b0, 5'd8,  6'd32, 0},
        '{3'b001, 5'd5,  4'h0, 1'b1, 40, 32, 1'b0, 5'd5,  6'd0,  0},
        '{3'b110, 5'd0,  4'h0, 1'b1, 32, 0,  1'b0, 5'd0,  6'd0,  0},
        '{3'b110, 5'd27, 4'h0, 1'b1, 32, 0,  1'b0, 5'd0,  6'd0,  0},
        '{3'b010, 5'd27, 4'h0, 1'b1, 32, -1, 1'b1, 5'd1,  6'd0,  0},
        '{3'b111, 5'd24, 4'h0, 1'b1, 32, 8,  1'b1, 5'd0,  6'd32, 0},
        '{3'b101, 5'd2,  4'h0, 1'b0, 32, 8,  1'b0, 5'd0,  6'd32, 0},
        '{3'b000, 5'd30, 4'h0, 1'b0, 32, 32, 1'b1, 5'd2,  6'd0,  0},
        '{3'b100, 5'd30, 4'h0, 1'b0, 32, 28, 1'b1, 5'd2,  6'd0,  0},
        '{3'b101, 5'd26, 4'h3, 1'b1, 32, -2, 1'b0, 5'd0,  6'd0,  10},
        '{3'b001, 5'd0,  4'h0, 1'b1, 32, 32, 1'b0, 5'd25, 6'd0,  0}
    };
    logic [2:0] ovx [4] = '{3'b000, 3'b110, 3'b001, 3'b010};

    ttx_acq #(.LOCK_PKTS(4), .MISS_LINES(8)) uut (
        .clock(clock), .rst(rst), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .line_pulse(line_pulse), .pkt_start(pkt_start), .pkt_mag(pkt_mag), .pkt_num(pkt_num),
        .pkt_desig(pkt_desig), .pkt_acquire(pkt_acquire), .pkt_mag_match(pkt_mag_match),
        .pr_no_check(pr_no_check), .byte_valid(byte_valid), .byte_data(byte_data),
        .timing_525(timing_525), .mem_we(mem_we), .mem_ext(mem_ext), .mem_row(mem_row),
        .mem_col(mem_col), .mem_data(mem_data), .mem_check(mem_check),
        .trip_valid(trip_valid), .trip_data(trip_data), .trip_desig(trip_desig),
        .trip_num(trip_num));

    ttx_slicer_model sl (
        .clock(clock), .line_pulse(line_pulse), .pkt_start(pkt_start), .pkt_mag(pkt_mag),
        .pkt_num(pkt_num), .pkt_desig(pkt_desig), .pkt_acquire(pkt_acquire),
        .pkt_mag_match(pkt_mag_match), .byte_valid(byte_valid), .byte_data(byte_data));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    task report_and_stop;
        $display("Comparisons %0d, mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Monitor keeps the first write of a packet and the last triplet seen
    always @(posedge clock) begin
        cyc++;
        if (mem_we === 1'b1) begin
            if (wcnt == 0) begin
                f_ext = mem_ext;
                f_row = mem_row;
                f_col = mem_col;
                f_chk = mem_check;
                f_data = mem_data;
            end
            wcnt++;
        end
        if (trip_valid === 1'b1) begin
            tcnt++;
            t_desig = trip_desig;
            t_num = trip_num;
            t_data = trip_data;
        end
        if (cyc == 20000) begin
            err_total++;
            report_and_stop;
        end
    end

    // Register access; holds the request until waitrequest is seen low
    task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge clock);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic run_row(input ttx_row_s r, input logic mm, input int gap);
        @(negedge clock);
        wcnt = 0;
        tcnt = 0;
        sl.send(r.m, r.n, r.d, r.a, mm, r.cnt, gap);
        repeat (4) @(posedge clock);
        if (r.wr >= 0) `CHK("writes", r.wr, wcnt)
        if (r.wr != 0 && r.wr != -2) begin
            `CHK("ext", r.ext, f_ext)
            `CHK("row", r.row, f_row)
            `CHK("col", r.col, f_col)
            `CHK("data", 8'h5A, f_data)
        end
        `CHK("trips", r.trips, tcnt)
    endtask

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        pr_no_check = 1'b0;
        err_total = 0;
        compares = 0;
        cyc = 0;
        wcnt = 0;
        tcnt = 0;
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        av(1'b0, 4'h8, 32'h0);
        `CHK("status_rst", 32'h0, rd)
        `CHK("timing_rst", 1'b0, timing_525)
        repeat (4) sl.send(3'b001, 5'd5, 4'h0, 1'b0, 1'b1, 0, 0);
        av(1'b0, 4'h8, 32'h0);
        `CHK("lock625", 5'h01, rd[4:0])
        sl.lines(8);
        av(1'b0, 4'h8, 32'h0);
        `CHK("seek525", 5'h10, rd[4:0])
        repeat (4) sl.send(3'b001, 5'd5, 4'h0, 1'b0, 1'b1, 0, 0);
        av(1'b0, 4'h8, 32'h0);
        `CHK("lock525", 5'h12, rd[4:0])
        av(1'b1, 4'h8, 32'h0);
        sl.send(3'b110, 5'd27, 4'h0, 1'b0, 1'b1, 0, 0);
        av(1'b0, 4'h8, 32'h0);
        `CHK("link_tab", 1'b0, rd[3])
        sl.send(3'b010, 5'd27, 4'h0, 1'b0, 1'b1, 0, 0);
        sl.send(3'b000, 5'd30, 4'h0, 1'b0, 1'b1, 0, 0);
        av(1'b0, 4'h8, 32'h0);
        `CHK("flags_set", 2'b11, rd[3:2])
        av(1'b1, 4'h8, 32'h0);
        av(1'b0, 4'h8, 32'h0);
        `CHK("flags_clr", 2'b00, rd[3:2])
        av(1'b1, 4'h4, 32'h1);
        av(1'b1, 4'h0, 32'h0);
        foreach (rows[i]) run_row(rows[i], 1'b1, i % 2);
        `CHK("trip_desig", 5'h13, t_desig)
        `CHK("trip_last", 4'h9, t_num)
        `CHK("trip_data", 24'h444746, t_data)
        run_row(rows[0], 1'b1, 0);
        `CHK("chk_par", CHK_PARITY, f_chk)
        av(1'b1, 4'h0, 32'h1);
        run_row(rows[0], 1'b1, 0);
        `CHK("chk_8bit", CHK_NONE, f_chk)
        av(1'b1, 4'h0, 32'h2);
        pr_no_check <= 1'b1;
        run_row('{3'b111, 5'd24, 4'h0, 1'b1, 32, 8, 1'b0, 5'd24, 6'd32, 0}, 1'b1, 0);
        `CHK("chk_req", CHK_NONE, f_chk)
        pr_no_check <= 1'b0;
        av(1'b1, 4'h0, 32'h4);
        // Wrong magazine in parallel mode gives no rolling time
        run_row('{3'b101, 5'd2, 4'h0, 1'b0, 32, 0, 1'b0, 5'd0, 6'd32, 0}, 1'b0, 0);
        run_row(rows[6], 1'b1, 0);
        for (int k = 1; k < 4; k++) begin
            av(1'b1, 4'h4, 32'(k));
            av(1'b0, 4'h8, 32'h0);
            `CHK("override", ovx[k], {rd[4], rd[1:0]})
            `CHK("timing", ovx[k][2], timing_525)
        end
        // Frozen clock enable drops a whole packet
        ce <= 1'b0;
        run_row('{3'b001, 5'd5, 4'h0, 1'b1, 32, 0, 1'b0, 5'd0, 6'd0, 0}, 1'b1, 0);
        ce <= 1'b1;
        // Reset in mid-run returns every register to its idle value
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        av(1'b0, 4'h0, 32'h0);
        `CHK("ctrl_rst", 32'h0, rd)
        av(1'b0, 4'h4, 32'h0);
        `CHK("ovr_rst", 32'h0, rd)
        av(1'b0, 4'h8, 32'h0);
        `CHK("status_mid", 32'h0, rd)
        av(1'b1, 4'hC, 32'hFF);
        av(1'b0, 4'hC, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        report_and_stop;
    end
endmodule
